// File: nrl_pkg.sv
package nrl_pkg;

  // Operation modes
  typedef enum logic [1:0] {
    NRL_MODE_EXT,
    NRL_MODE_NET,
    NRL_MODE_PANEL
  } nrl_mode_t;

  // Link rate selection codes
  localparam logic [2:0] LINK_RATE_156K = 3'h0;
  localparam logic [2:0] LINK_RATE_625K = 3'h1;
  localparam logic [2:0] LINK_RATE_2M5  = 3'h2;
  localparam logic [2:0] LINK_RATE_5M   = 3'h3;
  localparam logic [2:0] LINK_RATE_10M  = 3'h4;
  localparam logic [2:0] LINK_RATE_RST  = 3'h0;

  localparam logic [6:0] STATION_MIN = 7'h01;
  localparam logic [6:0] STATION_MAX = 7'h40;
  localparam logic [6:0] STATION_RST = 7'h01;

  localparam logic [15:0] FREQ_UNSIGNED_MAX = 16'h9c40;
  localparam logic [15:0] FREQ_RST          = 16'h0000;

  localparam logic [7:0] ram_freq_write_code    = 8'hed;
  localparam logic [7:0] eeprom_freq_write_code = 8'hee;
  localparam logic [7:0] WRITE_MODE_ERR_CODE    = 8'h01;

  // Command lockout after reset release, 1 s at 10 MHz
  localparam int unsigned CLK_HZ        = 10000000;
  localparam int unsigned LOCKOUT_MS    = 1000;
  localparam int unsigned LOCKOUT_CYC   = (CLK_HZ / 1000) * LOCKOUT_MS;

  // LED blink half period in cycles
  localparam int unsigned BLINK_CYC     = 2500000;

  // Commands arriving from the master
  typedef struct packed {
    logic        drive_reset;
    logic        fault_reset_request_bit;
    logic        fwd;
    logic        rev;
    logic        volatile_freq_write_request;
    logic        nonvolatile_freq_write_request;
    logic [15:0] frequency_setpoint_word;
    logic        instr_valid;
    logic [7:0]  instr_code;
    logic [15:0] instr_data;
  } nrl_cmd_t;

  // Decoded run command
  typedef struct packed {
    logic        run_fwd;
    logic        run_rev;
    logic [15:0] freq_mag;
  } nrl_run_t;

  function automatic logic rate_valid(input logic [2:0] r);
    return r <= LINK_RATE_10M;
  endfunction

  function automatic logic station_valid(input logic [6:0] s);
    return (s >= STATION_MIN) && (s <= STATION_MAX);
  endfunction

endpackage : nrl_pkg

// File: nrl_lockout.sv
`timescale 1ns/1ps
`default_nettype none
// Down counter that holds busy_o for a number of cycles after start_i falls
module nrl_lockout #(
  parameter int unsigned CYCLES = 10000000
) (
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  input  wire logic start_i,
  output logic      busy_o
);
  localparam int unsigned W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_q;
  logic         start_q;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
    end else if (start_q && !start_i) begin
      cnt_q <= W'(CYCLES);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= start_i || (start_q && !start_i) || (cnt_q > W'(1));
    end
  end

endmodule // nrl_lockout
`default_nettype wire

// File: nrl_net_reset_cfg.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE_01: Network drive reset accepted only in network mode, fault or not.
// RULE_02: Reset scope 0: fault reset bit honoured in every operation mode.
// RULE_03: Reset scope 1: fault reset bit honoured only in network mode.
// RULE_04: Fault reset bit acts only while a protective trip is active.
// RULE_05: Reset terminal or power loss resets the drive in every mode.
// RULE_06: Line error or option fault blocks every network reset command.
// RULE_07: After network-mode reset start in external mode unless startup setting nonzero.
// RULE_08: Link keeps running in reset; commands ignored about 1 s after release.
// RULE_09: Station number 1 to 64, default 1, one station occupied.
// RULE_10: Master gives unique, gapless station numbers; wiring order free.
// RULE_11: Station or rate change blinks LED; applied at power-up or reset terminal.
// RULE_12: Link rate codes 0..4 map 156k to 10M, default 0.
// RULE_13: Sign setting 0: setpoint unsigned 0 to 40000.
// RULE_14: Sign setting 1: setpoint two's complement -32768 to 32767.
// RULE_15: Signed negative setpoint inverts the commanded direction.
// RULE_16: Signed mode nonvolatile write request reports write mode error H01.
// RULE_17: Signed, extension nonzero, both write requests: volatile one wins.
// RULE_18: Power-up or drive reset: sign positive, frequency 0.
// RULE_19: Writes via codes ram or eeprom frequency leave sign unchanged.
module nrl_net_reset_cfg
  import nrl_pkg::*;
#(
  parameter int unsigned LOCKOUT_CYCLES = nrl_pkg::LOCKOUT_CYC,
  parameter int unsigned BLINK_CYCLES   = nrl_pkg::BLINK_CYC
) (
  input  wire logic                clk_sys_i,
  input  wire logic                nrst_i,
  input  wire nrl_pkg::nrl_cmd_t   cmd_i,
  input  wire nrl_pkg::nrl_mode_t  mode_i,
  input  wire logic                trip_active_i,
  input  wire logic                line_error_i,
  input  wire logic                option_fault_i,
  input  wire logic                external_reset_terminal_i,
  input  wire logic                reset_scope_setting_i,
  input  wire logic                startup_mode_nonzero_i,
  input  wire logic                setpoint_sign_setting_i,
  input  wire logic [6:0]          station_number_setting_i,
  input  wire logic [2:0]          link_rate_setting_i,
  input  wire logic [4:0]          link_extension_setting_i,
  output logic                     drive_reset_o,
  output logic                     fault_reset_o,
  output logic                     force_ext_mode_o,
  output logic                     force_net_mode_o,
  output logic                     cmd_locked_o,
  output logic [6:0]               station_o,
  output logic [2:0]               link_rate_o,
  output logic                     led_link_err_o,
  output nrl_pkg::nrl_run_t        run_o,
  output logic                     sign_neg_o,
  output logic                     write_err_o,
  output logic [7:0]               write_err_code_o
);
  import nrl_pkg::*;

  // Counter widths follow the parameters so a longer blink or lockout is not cut short
  localparam int unsigned BW = $clog2(BLINK_CYCLES + 1);
  localparam int unsigned SW = $clog2(LOCKOUT_CYCLES + 4);

  logic        net_ok;
  logic        drv_rst_acc;
  logic        flt_rst_acc;
  logic        lock_busy;
  logic        term_q;
  logic        term_rise;
  logic        pending_q;
  logic        applied_q;
  logic [BW-1:0] blink_q;
  logic        blink_ph_q;
  logic        signed_mode;
  logic        vol_wr;
  logic        nv_wr;
  logic        both_ok;
  logic [15:0] freq_q;
  logic        neg_q;
  logic        lock_start;
  logic [SW-1:0] since_q;

  // Network resets are blocked under a link or option fault
  assign net_ok      = !line_error_i && !option_fault_i; // RULE_06
  assign drv_rst_acc = net_ok && cmd_i.drive_reset && (mode_i == NRL_MODE_NET); // RULE_01
  assign flt_rst_acc = net_ok && cmd_i.fault_reset_request_bit && trip_active_i // RULE_04
                       && (!reset_scope_setting_i || (mode_i == NRL_MODE_NET)); // RULE_02 RULE_03
  assign term_rise   = external_reset_terminal_i && !term_q;
  // Fault reset alone never opens a lockout; only drive resets do
  assign lock_start  = drv_rst_acc || external_reset_terminal_i; // RULE_08

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      term_q <= 1'b0;
    end else begin
      term_q <= external_reset_terminal_i;
    end
  end

  // Reset outputs
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drive_reset_o <= 1'b1; // RULE_05
      fault_reset_o <= 1'b0;
    end else begin
      drive_reset_o <= drv_rst_acc || external_reset_terminal_i; // RULE_05
      fault_reset_o <= flt_rst_acc;
    end
  end

  // Startup mode after a reset taken in network mode
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      force_ext_mode_o <= 1'b0;
      force_net_mode_o <= 1'b0;
    end else if (drv_rst_acc || (external_reset_terminal_i && mode_i == NRL_MODE_NET)) begin
      force_ext_mode_o <= !startup_mode_nonzero_i; // RULE_07
      force_net_mode_o <= startup_mode_nonzero_i;  // RULE_07
    end else begin
      force_ext_mode_o <= 1'b0;
      force_net_mode_o <= 1'b0;
    end
  end

  // Lockout of control commands after reset release
  nrl_lockout #(
    .CYCLES (LOCKOUT_CYCLES)
  ) u_lockout (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .start_i   (lock_start),
    .busy_o    (lock_busy)
  );

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmd_locked_o <= 1'b1;
    end else begin
      cmd_locked_o <= lock_busy; // RULE_08
    end
  end

  // Cycles since the last reset request; power-up starts saturated, so no lockout
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      since_q <= SW'(LOCKOUT_CYCLES + 3);
    end else if (lock_start) begin
      since_q <= '0;
    end else if (since_q != SW'(LOCKOUT_CYCLES + 3)) begin
      since_q <= since_q + SW'(1);
    end
  end

  // Station and rate: captured after power-up and on reset terminal
  // Out-of-range settings are refused; the LED then keeps blinking until fixed
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      station_o   <= STATION_RST;
      link_rate_o <= LINK_RATE_RST;
      applied_q   <= 1'b0;
    end else if (!applied_q || term_rise) begin
      applied_q <= 1'b1;
      if (station_valid(station_number_setting_i)) begin
        station_o <= station_number_setting_i; // RULE_09 RULE_11
      end
      if (rate_valid(link_rate_setting_i)) begin
        link_rate_o <= link_rate_setting_i; // RULE_12
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pending_q <= 1'b0;
    end else begin
      pending_q <= applied_q && ((station_number_setting_i != station_o)
                   || (link_rate_setting_i != link_rate_o)); // RULE_11
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      blink_q    <= '0;
      blink_ph_q <= 1'b0;
    end else if (!pending_q) begin
      blink_q    <= '0;
      blink_ph_q <= 1'b0;
    end else if (blink_q >= BW'(BLINK_CYCLES - 1)) begin
      blink_q    <= '0;
      blink_ph_q <= !blink_ph_q;
    end else begin
      blink_q <= blink_q + BW'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      led_link_err_o <= 1'b0;
    end else begin
      led_link_err_o <= pending_q && !blink_ph_q; // RULE_11
    end
  end

  // Frequency setpoint handling
  assign signed_mode = setpoint_sign_setting_i;
  assign both_ok     = link_extension_setting_i != 5'h00;
  assign vol_wr      = cmd_i.volatile_freq_write_request && !lock_busy;
  assign nv_wr       = cmd_i.nonvolatile_freq_write_request && !lock_busy
                       && !(signed_mode && both_ok && vol_wr); // RULE_17

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      freq_q <= FREQ_RST; // RULE_18
      neg_q  <= 1'b0;     // RULE_18
    end else if (drive_reset_o) begin
      freq_q <= FREQ_RST; // RULE_18
      neg_q  <= 1'b0;     // RULE_18
    end else if (!lock_busy && cmd_i.instr_valid
                 && (cmd_i.instr_code == ram_freq_write_code
                     || cmd_i.instr_code == eeprom_freq_write_code)) begin
      // Instruction writes carry a magnitude only; the stored sign stays
      freq_q <= cmd_i.instr_data; // RULE_19
    end else if (vol_wr || (nv_wr && !signed_mode)) begin
      if (signed_mode) begin
        neg_q  <= cmd_i.frequency_setpoint_word[15]; // RULE_14
        freq_q <= cmd_i.frequency_setpoint_word[15]
                  ? 16'(~cmd_i.frequency_setpoint_word + 16'h1)
                  : cmd_i.frequency_setpoint_word;
      end else begin
        neg_q  <= 1'b0;
        freq_q <= (cmd_i.frequency_setpoint_word > FREQ_UNSIGNED_MAX)
                  ? FREQ_UNSIGNED_MAX : cmd_i.frequency_setpoint_word; // RULE_13
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      write_err_o      <= 1'b0;
      write_err_code_o <= 8'h00;
    end else begin
      write_err_o      <= signed_mode && nv_wr; // RULE_16
      write_err_code_o <= (signed_mode && nv_wr) ? WRITE_MODE_ERR_CODE : 8'h00;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_o      <= '0;
      sign_neg_o <= 1'b0;
    end else begin
      sign_neg_o    <= neg_q;
      run_o.freq_mag <= freq_q;
      // Negative setpoint swaps the start direction
      run_o.run_fwd <= !lock_busy && (neg_q ? cmd_i.rev : cmd_i.fwd); // RULE_15
      run_o.run_rev <= !lock_busy && (neg_q ? cmd_i.fwd : cmd_i.rev); // RULE_15
    end
  end

  a_net_reset_block: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_06
    (line_error_i || option_fault_i) && !external_reset_terminal_i |=> !drive_reset_o && !fault_reset_o)
    else $error("network reset taken during fault");
  a_drv_reset_mode: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_01
    cmd_i.drive_reset && net_ok && mode_i == NRL_MODE_NET |=> drive_reset_o)
    else $error("network drive reset missed");
  a_flt_no_trip: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_04
    !trip_active_i |=> !fault_reset_o)
    else $error("fault reset without trip");
  a_flt_scope: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_03
    reset_scope_setting_i && mode_i != NRL_MODE_NET |=> !fault_reset_o)
    else $error("fault reset outside network mode");
  a_flt_scope0: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_02
    !reset_scope_setting_i && cmd_i.fault_reset_request_bit && trip_active_i && net_ok
    |=> fault_reset_o)
    else $error("fault reset missed");
  a_term_reset: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_05
    external_reset_terminal_i |=> drive_reset_o ##1 cmd_locked_o)
    else $error("terminal reset missed");
  a_h01_code: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_16
    write_err_o |-> write_err_code_o == WRITE_MODE_ERR_CODE)
    else $error("wrong write error code");
  a_freq_clear: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_18
    drive_reset_o |=> freq_q == FREQ_RST && !neg_q)
    else $error("setpoint kept over reset");
  a_station_range: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_09
    station_o >= STATION_MIN && station_o <= STATION_MAX)
    else $error("station out of range");
  a_rate_range: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_12
    link_rate_o <= LINK_RATE_10M)
    else $error("link rate out of range");

  // Lockout timing, counted from the last cycle a reset was requested
  a_lock_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_08
    since_q >= SW'(1) && since_q <= SW'(LOCKOUT_CYCLES + 1) |-> cmd_locked_o)
    else $error("commands accepted inside lockout");
  a_lock_end: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_08
    since_q == SW'(LOCKOUT_CYCLES + 2) |-> !cmd_locked_o)
    else $error("lockout longer than its count");
  a_run_locked: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_08
    lock_busy |=> !run_o.run_fwd && !run_o.run_rev)
    else $error("run command passed during lockout");

  // Startup mode and link indicator
  a_start_ext: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_07
    drv_rst_acc && !startup_mode_nonzero_i |=> force_ext_mode_o && !force_net_mode_o)
    else $error("external startup not requested");
  a_start_net: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_07
    drv_rst_acc && startup_mode_nonzero_i |=> force_net_mode_o && !force_ext_mode_o)
    else $error("network startup not requested");
  a_led_quiet: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_11
    !pending_q |=> !led_link_err_o)
    else $error("link error led lit with nothing pending");

  // Setpoint decoding and write requests
  a_freq_clamp: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_13
    !setpoint_sign_setting_i && vol_wr && !drive_reset_o && !cmd_i.instr_valid
    |=> freq_q <= FREQ_UNSIGNED_MAX && !neg_q)
    else $error("unsigned setpoint out of range");
  a_neg_sign: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_14
    setpoint_sign_setting_i && vol_wr && !drive_reset_o && !cmd_i.instr_valid
    && cmd_i.frequency_setpoint_word[15] |=> neg_q)
    else $error("negative setpoint sign lost");
  a_dir_swap: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_15
    !lock_busy && neg_q && cmd_i.fwd && !cmd_i.rev |=> run_o.run_rev && !run_o.run_fwd)
    else $error("negative setpoint did not swap direction");
  a_dir_keep: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_15
    !lock_busy && !neg_q && cmd_i.fwd && !cmd_i.rev |=> run_o.run_fwd && !run_o.run_rev)
    else $error("positive setpoint changed direction");
  a_nv_error: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_16
    setpoint_sign_setting_i && !lock_busy && cmd_i.nonvolatile_freq_write_request
    && !cmd_i.volatile_freq_write_request |=> write_err_o)
    else $error("signed nonvolatile write not refused");
  a_vol_first: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_17
    setpoint_sign_setting_i && both_ok && vol_wr && cmd_i.nonvolatile_freq_write_request
    |=> !write_err_o)
    else $error("volatile write did not take precedence");
  a_sign_kept: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE_19
    !drive_reset_o && !lock_busy && cmd_i.instr_valid
    && (cmd_i.instr_code == ram_freq_write_code
        || cmd_i.instr_code == eeprom_freq_write_code) |=> $stable(neg_q))
    else $error("instruction write changed the sign");

  c_net_reset: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) drv_rst_acc);
  c_flt_reset: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) flt_rst_acc);
  c_led_blink: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) led_link_err_o);
  c_neg_run:   cover property (@(posedge clk_sys_i) disable iff (!nrst_i) sign_neg_o && run_o.run_rev);
  c_write_err: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) write_err_o);

endmodule // nrl_net_reset_cfg
`default_nettype wire

// File: nrl_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// Field-bus master: changes the command word only at falling edges
module nrl_master_model
  import nrl_pkg::*;
(
  input  wire logic           clk_sys_i,
  output var nrl_pkg::nrl_cmd_t cmd_o
);
  // This node is given its own station; numbering is unique and gapless
  localparam logic [6:0] OWN_STATION = 7'h01;
  initial cmd_o = '0;
  task automatic set_run(input logic f, input logic r);
    @(negedge clk_sys_i);
    cmd_o.fwd = f;
    cmd_o.rev = r;
  endtask
  task automatic set_word(input logic [15:0] w);
    @(negedge clk_sys_i);
    cmd_o.frequency_setpoint_word = w;
  endtask
  task automatic write_req(input logic v, input logic nv);
    @(negedge clk_sys_i);
    cmd_o.volatile_freq_write_request = v;
    cmd_o.nonvolatile_freq_write_request = nv;
  endtask
  task automatic reset_req(input logic l);
    @(negedge clk_sys_i);
    cmd_o.drive_reset = l;
  endtask
  task automatic fault_req(input logic l);
    @(negedge clk_sys_i);
    cmd_o.fault_reset_request_bit = l;
  endtask
  task automatic instr(input logic [7:0] c, input logic [15:0] d);
    @(negedge clk_sys_i);
    cmd_o.instr_code = c;
    cmd_o.instr_data = d;
    cmd_o.instr_valid = 1'b1;
    @(negedge clk_sys_i);
    cmd_o.instr_valid = 1'b0;
  endtask
endmodule // nrl_master_model
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import nrl_pkg::*;
  localparam int unsigned LOCK = 20;
  logic       clk_sys_i = 1'b0;
  logic       nrst_i;
  nrl_cmd_t   cmd;
  nrl_mode_t  md;
  logic       trip, le, of, tm;
  logic       scope, stm, sgn;
  logic [6:0] st_set;
  logic [2:0] rt_set;
  logic [4:0] ext;
  logic       drv, flt, fext, fnet, lck, led, werr, sneg, err_seen;
  logic [6:0] st, xs;
  logic [2:0] rt, xr;
  logic [7:0] ecode, err_code;
  logic [1:0] seen;
  nrl_run_t   run;
  nrl_mode_t  modes[3] = '{NRL_MODE_EXT, NRL_MODE_NET, NRL_MODE_PANEL};
  logic [6:0] st_tab[5] = '{7'h05, 7'h40, 7'h01, 7'h00, 7'h41};
  logic [2:0] rt_tab[5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  int         mismatches = 0;
  int         n_checks = 0;

  always #50 clk_sys_i = ~clk_sys_i;

  nrl_master_model i_master (.clk_sys_i(clk_sys_i), .cmd_o(cmd));
  nrl_net_reset_cfg #(.LOCKOUT_CYCLES(LOCK), .BLINK_CYCLES(4)) i_dut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cmd_i(cmd), .mode_i(md),
    .trip_active_i(trip), .line_error_i(le), .option_fault_i(of),
    .external_reset_terminal_i(tm), .reset_scope_setting_i(scope),
    .startup_mode_nonzero_i(stm), .setpoint_sign_setting_i(sgn),
    .station_number_setting_i(st_set), .link_rate_setting_i(rt_set),
    .link_extension_setting_i(ext), .drive_reset_o(drv), .fault_reset_o(flt),
    .force_ext_mode_o(fext), .force_net_mode_o(fnet), .cmd_locked_o(lck),
    .station_o(st), .link_rate_o(rt), .led_link_err_o(led), .run_o(run),
    .sign_neg_o(sneg), .write_err_o(werr), .write_err_code_o(ecode));

  task automatic chk_val(input logic [17:0] got, input logic [17:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({17'h0, got}, {17'h0, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic wait_unlock();
    for (int i = 0; i < 4 * LOCK + 40 && lck !== 1'b0; i++) cyc(1);
    chk_bit(lck, 1'b0);
  endtask
  task automatic wr_freq(input logic [15:0] w, input logic v, input logic nv);
    i_master.set_word(w);
    i_master.write_req(v, nv);
    cyc(3);
    err_seen = werr;
    err_code = ecode;
    i_master.write_req(1'b0, 1'b0);
    cyc(3);
  endtask
  task automatic chk_run(input logic f, input logic r, input logic [15:0] m, input logic n);
    chk_val(run, {f, r, m});
    chk_bit(sneg, n);
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #2000000;
    mismatches++;
    wrap_up();
  end

  initial begin
    nrst_i = 1'b0;
    md = NRL_MODE_NET;
    {trip, le, of, tm, scope, stm, sgn} = 7'h00;
    st_set = 7'h01;
    rt_set = 3'h0;
    ext = 5'h00;
    cyc(7);
    chk_bit(drv, 1'b1);
    cyc(1);
    nrst_i = 1'b1;
    wait_unlock();
    chk_val({11'h0, st}, 18'h1);
    chk_val({15'h0, rt}, {15'h0, LINK_RATE_RST});
    chk_run(1'b0, 1'b0, 16'h0000, 1'b0);
    foreach (modes[m]) for (int s = 0; s < 2; s++) for (int t = 0; t < 2; t++)
      for (int e = 0; e < 3; e++) begin
        md = modes[m];
        scope = s[0];
        trip = t[0];
        le = (e == 1);
        of = (e == 2);
        i_master.fault_req(1'b1);
        cyc(2);
        chk_bit(flt, t[0] && e == 0 && (!s[0] || m == 1));
        i_master.fault_req(1'b0);
        cyc(2);
        wait_unlock();
      end
    foreach (modes[m]) for (int e = 0; e < 3; e++) begin
      md = modes[m];
      le = (e == 1);
      of = (e == 2);
      i_master.reset_req(1'b1);
      cyc(3);
      chk_bit(drv, m == 1 && e == 0);
      i_master.reset_req(1'b0);
      wait_unlock();
    end
    le = 1'b0;
    of = 1'b0;
    md = NRL_MODE_NET;
    for (int s = 0; s < 2; s++) begin
      stm = s[0];
      wr_freq(16'h1234, 1'b1, 1'b0);
      i_master.reset_req(1'b1);
      cyc(3);
      chk_bit(drv, 1'b1);
      chk_bit(fext, !s[0]);
      chk_bit(fnet, s[0]);
      i_master.reset_req(1'b0);
      wr_freq(16'h0555, 1'b1, 1'b0);
      chk_bit(lck, 1'b1);
      wait_unlock();
      chk_val({2'b00, run.freq_mag}, 18'h0);
    end
    trip = 1'b0;
    xs = 7'h01;
    xr = 3'h0;
    foreach (st_tab[i]) begin
      st_set = st_tab[i];
      rt_set = rt_tab[i];
      md = modes[i % 3];
      seen = 2'b00;
      repeat (12) begin
        cyc(1);
        seen |= {led === 1'b1, led === 1'b0};
      end
      chk_val({11'h0, st}, {11'h0, xs});
      if (i < 3) chk_val({16'h0, seen}, 18'h3);
      if (st_tab[i] >= 7'h01 && st_tab[i] <= 7'h40) xs = st_tab[i];
      if (rt_tab[i] <= 3'h4) xr = rt_tab[i];
      tm = 1'b1;
      cyc(3);
      chk_bit(drv, 1'b1);
      tm = 1'b0;
      wait_unlock();
      chk_val({11'h0, st}, {11'h0, xs});
      chk_val({15'h0, rt}, {15'h0, xr});
      if (i < 3) chk_bit(led, 1'b0);
    end
    md = NRL_MODE_NET;
    i_master.set_run(1'b1, 1'b0);
    wr_freq(16'h9c40, 1'b1, 1'b0);
    chk_run(1'b1, 1'b0, 16'h9c40, 1'b0);
    wr_freq(16'hffff, 1'b1, 1'b0);
    chk_run(1'b1, 1'b0, FREQ_UNSIGNED_MAX, 1'b0);
    wr_freq(16'h0100, 1'b0, 1'b1);
    chk_bit(err_seen, 1'b0);
    sgn = 1'b1;
    wr_freq(16'hff38, 1'b1, 1'b0);
    chk_run(1'b0, 1'b1, 16'h00c8, 1'b1);
    i_master.set_run(1'b0, 1'b1);
    cyc(3);
    chk_run(1'b1, 1'b0, 16'h00c8, 1'b1);
    wr_freq(16'h7fff, 1'b1, 1'b0);
    chk_run(1'b0, 1'b1, 16'h7fff, 1'b0);
    i_master.set_run(1'b1, 1'b0);
    wr_freq(16'h8000, 1'b1, 1'b0);
    chk_run(1'b0, 1'b1, 16'h8000, 1'b1);
    wr_freq(16'h0200, 1'b0, 1'b1);
    chk_bit(err_seen, 1'b1);
    chk_val({10'h0, err_code}, {10'h0, WRITE_MODE_ERR_CODE});
    ext = 5'h01;
    wr_freq(16'h0300, 1'b1, 1'b1);
    chk_bit(err_seen, 1'b0);
    chk_run(1'b1, 1'b0, 16'h0300, 1'b0);
    wr_freq(16'hff00, 1'b1, 1'b0);
    i_master.instr(ram_freq_write_code, 16'h0050);
    cyc(3);
    chk_run(1'b0, 1'b1, 16'h0050, 1'b1);
    i_master.instr(eeprom_freq_write_code, 16'h0060);
    cyc(3);
    chk_run(1'b0, 1'b1, 16'h0060, 1'b1);
    wrap_up();
  end
endmodule // tb
`default_nettype wire
